// ---- ebpc_pkg.sv ----
package ebpc_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] REG_CFG    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR   = 8'h08;
    localparam logic [7:0] REG_WDATA  = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_CMD    = 8'h14;

    // Configuration register fields.
    localparam int CFG_CLK_EN_BIT = 0;
    localparam int CFG_ACK_EN_BIT = 1;
    localparam int CFG_WIDTH_LSB  = 2;
    localparam int CFG_STYLE_LSB  = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0001;

    // Command register fields.
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_CE_LSB    = 1;
    localparam int CMD_LANE_LSB  = 4;

    // Status register fields.
    localparam int ST_RATIO_LSB  = 0;
    localparam int ST_STYLE_BIT  = 2;
    localparam int ST_TEST_BIT   = 3;
    localparam int ST_BUSY_BIT   = 4;
    localparam int ST_CAPT_BIT   = 5;

    // Strap pins sampled on the shared address pins at reset.
    localparam int STRAP_RATIO_LSB = 3;
    localparam int STRAP_STYLE_BIT = 11;

    localparam int NUM_CE      = 6;
    localparam int ADDR_PINS   = 16;
    localparam logic [2:0] STRAP_SETTLE = 3'h4;
    localparam logic [2:0] STROBE_CYCLES = 3'h4;

    // Divide ratio codes of the external I/O clock.
    localparam logic [1:0] RATIO_FULL    = 2'h0;
    localparam logic [1:0] RATIO_HALF    = 2'h1;
    localparam logic [1:0] RATIO_THIRD   = 2'h2;
    localparam logic [1:0] RATIO_QUARTER = 2'h3;

    typedef enum logic [1:0] {
        EBPC_W32,
        EBPC_W16,
        EBPC_W8
    } ebpc_width_t;

    typedef struct packed {
        logic        write;
        logic [2:0]  ce;
        logic [3:0]  lanes;
        logic [31:0] addr;
        logic [31:0] wdata;
        ebpc_width_t width;
        logic        write_only;
        logic        use_ack;
    } ebpc_cmd_t;

    typedef struct packed {
        logic [1:0] ratio;
        logic       style;
        logic       test;
    } ebpc_strap_t;

endpackage

// ---- ebpc_sync3.sv ----
`timescale 1ns/10ps
module ebpc_sync3 #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire  [W-1:0] agree = ~(s2 ^ s3);
    wire  [W-1:0] next_q = (s3 & agree) | (q & ~agree);

    // A bit moves only when the second and third stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q  <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule

// ---- ebpc_clkdiv.sv ----
`timescale 1ns/10ps
module ebpc_clkdiv (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] ratio,
    input  wire logic       enable,
    output logic            clk_out
);
    logic [1:0] cnt;
    logic       div_q;
    logic       full_sel;
    logic       dbl_p;
    logic       dbl_n;
    wire        wrap      = (cnt >= ratio);
    wire  [1:0] next_cnt  = wrap ? 2'h0 : cnt + 2'h1;
    wire        next_lvl  = (ratio == ebpc_pkg::RATIO_QUARTER) ? (next_cnt < 2'h2)
                                                                : (next_cnt == 2'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 2'h0;
            div_q    <= 1'b0;
            full_sel <= 1'b0;
            dbl_p    <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            div_q    <= enable && (ratio != ebpc_pkg::RATIO_FULL) && next_lvl;
            full_sel <= enable && (ratio == ebpc_pkg::RATIO_FULL);
            dbl_p    <= ~dbl_p;
        end
    end

    // Full speed cannot come from one rising-edge flop, so a falling-edge copy is xored in.
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbl_n <= 1'b0;
        end else begin
            dbl_n <= dbl_p;
        end
    end

    assign clk_out = full_sel ? (dbl_p ^ dbl_n) : div_q;
endmodule

// ---- ebpc_top.sv ----
`timescale 1ns/10ps
// Contract
// - IO clock at ratio 1,2,3,4 from straps.
// - Clock enable cleared holds IO clock low.
// - Active-low strobe latches upper address bits.
// - Latch strobe pin input in reset, output after.
// - Six active-low chip enables, high from reset.
// - Active-low output enable, high from reset.
// - Active-low write strobe, high from reset.
// - Byte-enable style marks lanes on reads, writes.
// - Write-enable style marks lanes on writes only.
// - Lane strobe three is top byte, zero bottom.
// - Strap and channel bit select lane style.
// - Ready pin pulled up, input, paces accesses.
module ebpc_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        link_clk,
    output logic             ext_io_clock,
    input  wire logic [15:0] addr_pin_in,
    output logic      [15:0] addr_pin_out,
    output logic             addr_pin_oe,
    input  wire logic        upper_addr_latch_strobe_in,
    output logic             upper_addr_latch_strobe_out,
    output logic             upper_addr_latch_strobe_oe,
    output logic      [5:0]  chip_enable_n,
    output logic             output_enable_n,
    output logic             write_strobe_n,
    output logic      [3:0]  lane_strobe_n,
    input  wire logic [31:0] data_pin_in,
    output logic      [31:0] data_pin_out,
    output logic             data_pin_oe,
    input  wire logic        ack_ready_in,
    output logic             ack_ready_out,
    output logic             ack_ready_oe
);

    function automatic logic [3:0] width_lanes(ebpc_pkg::ebpc_width_t w, logic [3:0] lanes);
        logic [3:0] m;
        m = 4'hf;
        case (w)
            ebpc_pkg::EBPC_W16: m = 4'h3;
            ebpc_pkg::EBPC_W8:  m = 4'h1;
            default:            m = 4'hf;
        endcase
        return lanes & m;
    endfunction

    // ---------------- Bus clock domain ----------------
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] cfg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic        busy;
    logic        req_tgl;
    logic        done_s1;
    logic        done_s2;
    logic        done_s3;
    logic        captured;
    logic [2:0]  settle;
    ebpc_pkg::ebpc_strap_t strap;
    ebpc_pkg::ebpc_cmd_t   cmd;
    logic [3:0]  strap_pins;
    logic [31:0] link_rdata;
    logic        done_tgl;

    wire         take      = hsel && hready && htrans[1];
    wire         wr_cfg    = dp_valid && dp_write && (dp_addr == ebpc_pkg::REG_CFG);
    wire         wr_addr   = dp_valid && dp_write && (dp_addr == ebpc_pkg::REG_ADDR);
    wire         wr_wdata  = dp_valid && dp_write && (dp_addr == ebpc_pkg::REG_WDATA);
    wire         wr_cmd    = dp_valid && dp_write && (dp_addr == ebpc_pkg::REG_CMD) && !busy;
    wire         done_evt  = done_s2 != done_s3;
    wire [2:0]   cmd_ce    = hwdata[ebpc_pkg::CMD_CE_LSB +: 3];
    wire [5:0]   style_bits = cfg[ebpc_pkg::CFG_STYLE_LSB +: ebpc_pkg::NUM_CE];
    wire         chan_style = (cmd_ce < 3'h6) ? style_bits[cmd_ce] : 1'b0;
    wire [31:0]  status    = {26'h0, captured, busy, strap.test, strap.style, strap.ratio};
    wire [7:0]   rd_sel    = haddr[7:0];
    wire [31:0]  rd_mux    = (rd_sel == ebpc_pkg::REG_CFG)    ? cfg       :
                             (rd_sel == ebpc_pkg::REG_STATUS) ? status    :
                             (rd_sel == ebpc_pkg::REG_ADDR)   ? addr_reg  :
                             (rd_sel == ebpc_pkg::REG_WDATA)  ? wdata_reg :
                             (rd_sel == ebpc_pkg::REG_RDATA)  ? rdata_reg : 32'h0;

    // Strap levels cross in from the pins through three flops and a fourth output flop before capture.
    ebpc_sync3 #(.W(4), .INIT(4'h1)) u_strap_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({addr_pin_in[ebpc_pkg::STRAP_STYLE_BIT],
                 addr_pin_in[ebpc_pkg::STRAP_RATIO_LSB +: 2],
                 upper_addr_latch_strobe_in}),
        .q     (strap_pins)
    );

    // The straps are taken once the chain has refilled after release, well before the
    // link side turns the address and latch strobe pins into outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle   <= 3'h0;
            captured <= 1'b0;
            strap    <= '0;
        end else if (!captured) begin
            settle <= settle + 3'h1;
            if (settle == ebpc_pkg::STRAP_SETTLE) begin
                captured    <= 1'b1;
                strap.ratio <= strap_pins[2:1];
                strap.style <= strap_pins[3];
                strap.test  <= strap_pins[0];
            end
        end
    end

    ebpc_clkdiv u_clkdiv (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ratio   (strap.ratio),
        .enable  (cfg[ebpc_pkg::CFG_CLK_EN_BIT] && captured),
        .clk_out (ext_io_clock)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_addr   <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_valid <= take;
            dp_write <= take && hwrite;
            dp_addr  <= haddr[7:0];
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg       <= ebpc_pkg::CFG_RESET;
            addr_reg  <= 32'h0;
            wdata_reg <= 32'h0;
        end else begin
            if (wr_cfg) begin
                cfg <= hwdata;
            end
            if (wr_addr) begin
                addr_reg <= hwdata;
            end
            if (wr_wdata) begin
                wdata_reg <= hwdata;
            end
        end
    end

    // A command is frozen with its configuration so the link side sees stable words.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd       <= '0;
            busy      <= 1'b0;
            req_tgl   <= 1'b0;
            rdata_reg <= 32'h0;
            done_s1   <= 1'b0;
            done_s2   <= 1'b0;
            done_s3   <= 1'b0;
        end else begin
            done_s1 <= done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            if (wr_cmd) begin
                cmd.write      <= hwdata[ebpc_pkg::CMD_WRITE_BIT];
                cmd.ce         <= cmd_ce;
                cmd.lanes      <= hwdata[ebpc_pkg::CMD_LANE_LSB +: 4];
                cmd.addr       <= addr_reg;
                cmd.wdata      <= wdata_reg;
                cmd.width      <= ebpc_pkg::ebpc_width_t'(cfg[ebpc_pkg::CFG_WIDTH_LSB +: 2]);
                cmd.write_only <= strap.style ^ chan_style;
                cmd.use_ack    <= cfg[ebpc_pkg::CFG_ACK_EN_BIT];
                req_tgl        <= ~req_tgl;
                busy           <= 1'b1;
            end else if (done_evt) begin
                busy      <= 1'b0;
                rdata_reg <= link_rdata;
            end
        end
    end

    // ---------------- Link clock domain ----------------
    typedef enum logic [2:0] {
        L_IDLE,
        L_UPPER,
        L_LOWER,
        L_STROBE,
        L_HOLD
    } ebpc_lstate_t;

    ebpc_lstate_t lstate;
    logic        lrst_s1;
    logic        lrst_n;
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic [2:0]  wait_cnt;
    logic        ack_n;

    wire         new_req   = req_s2 != req_s3;
    wire [5:0]   ce_dec    = (cmd.ce < 3'h6) ? 6'(6'h1 << cmd.ce) : 6'h0;
    wire         lanes_on  = cmd.write || !cmd.write_only;
    wire [3:0]   lane_act  = lanes_on ? width_lanes(cmd.width, cmd.lanes) : 4'h0;
    wire         strobe_end = cmd.use_ack ? !ack_n : (wait_cnt == 3'h1);

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_s1 <= 1'b0;
            lrst_n  <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_n  <= lrst_s1;
        end
    end

    ebpc_sync3 #(.W(1), .INIT(1'b1)) u_ack_sync (
        .clk   (link_clk),
        .rst_n (lrst_n),
        .d     (ack_ready_in),
        .q     (ack_n)
    );

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // Pins stay inputs until the synchronised release, so straps are never driven over.
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate                      <= L_IDLE;
            wait_cnt                    <= 3'h0;
            addr_pin_out                <= 16'h0;
            addr_pin_oe                 <= 1'b0;
            upper_addr_latch_strobe_out <= 1'b1;
            upper_addr_latch_strobe_oe  <= 1'b0;
            chip_enable_n               <= 6'h3f;
            output_enable_n             <= 1'b1;
            write_strobe_n              <= 1'b1;
            lane_strobe_n               <= 4'hf;
            data_pin_out                <= 32'h0;
            data_pin_oe                 <= 1'b0;
            ack_ready_out               <= 1'b1;
            ack_ready_oe                <= 1'b0;
            link_rdata                  <= 32'h0;
            done_tgl                    <= 1'b0;
        end else begin
            addr_pin_oe                <= 1'b1;
            upper_addr_latch_strobe_oe <= 1'b1;
            case (lstate)
                L_IDLE: begin
                    if (new_req) begin
                        addr_pin_out                <= cmd.addr[31:16];
                        upper_addr_latch_strobe_out <= 1'b0;
                        lstate                      <= L_UPPER;
                    end
                end
                L_UPPER: begin
                    upper_addr_latch_strobe_out <= 1'b1;
                    addr_pin_out                <= cmd.addr[15:0];
                    chip_enable_n               <= ~ce_dec;
                    data_pin_out                <= cmd.wdata;
                    data_pin_oe                 <= cmd.write;
                    lstate                      <= L_LOWER;
                end
                L_LOWER: begin
                    output_enable_n <= cmd.write;
                    write_strobe_n  <= !cmd.write;
                    lane_strobe_n   <= ~lane_act;
                    wait_cnt        <= ebpc_pkg::STROBE_CYCLES;
                    lstate          <= L_STROBE;
                end
                L_STROBE: begin
                    if (wait_cnt != 3'h0) begin
                        wait_cnt <= wait_cnt - 3'h1;
                    end
                    if (strobe_end) begin
                        link_rdata      <= data_pin_in;
                        output_enable_n <= 1'b1;
                        write_strobe_n  <= 1'b1;
                        lane_strobe_n   <= 4'hf;
                        lstate          <= L_HOLD;
                    end
                end
                L_HOLD: begin
                    chip_enable_n <= 6'h3f;
                    data_pin_oe   <= 1'b0;
                    done_tgl      <= ~done_tgl;
                    lstate        <= L_IDLE;
                end
                default: begin
                    lstate <= L_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- ebpc_monitor.sv ----
`timescale 1ns/10ps
module ebpc_monitor (
    input wire logic       link_clk,
    input wire logic       hresetn,
    input wire logic       upper_addr_latch_strobe_out,
    input wire logic       upper_addr_latch_strobe_oe,
    input wire logic [5:0] chip_enable_n,
    input wire logic       output_enable_n,
    input wire logic       write_strobe_n,
    input wire logic [3:0] lane_strobe_n,
    input wire logic       data_pin_oe,
    input wire logic       ack_ready_oe
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!hresetn);
    wire logic strobing = !output_enable_n || !write_strobe_n;
    sequence latch_pulse;
        $fell(upper_addr_latch_strobe_out) ##1 upper_addr_latch_strobe_out;
    endsequence
    a_rst_idle_high: assert property ($rose(hresetn) |-> chip_enable_n == 6'h3f
        && output_enable_n && write_strobe_n && lane_strobe_n == 4'hf)
        else $error("strobes not idle after reset");
    a_rst_pin_input: assert property ($rose(hresetn) |->
        !upper_addr_latch_strobe_oe ##[1:3] upper_addr_latch_strobe_oe)
        else $error("latch pin direction wrong");
    a_latch_one_cycle: assert property ($fell(upper_addr_latch_strobe_out) |=>
        upper_addr_latch_strobe_out) else $error("latch pulse too long");
    a_strobe_after_latch: assert property (latch_pulse |-> ##1 strobing)
        else $error("no strobe after latch");
    a_one_chip_enable: assert property ($onehot0(~chip_enable_n))
        else $error("several chip enables low");
    a_oe_we_apart: assert property (!(!output_enable_n && !write_strobe_n))
        else $error("read and write strobes together");
    a_no_drive_read: assert property (!output_enable_n |-> !data_pin_oe)
        else $error("data driven during read");
    a_lanes_in_strobe: assert property (lane_strobe_n != 4'hf |-> strobing)
        else $error("lane strobe outside access");
    a_ready_input: assert property (!ack_ready_oe)
        else $error("ready pin driven");
endmodule
bind ebpc_top ebpc_monitor mon_u (.link_clk(link_clk), .hresetn(hresetn),
    .upper_addr_latch_strobe_out(upper_addr_latch_strobe_out),
    .upper_addr_latch_strobe_oe(upper_addr_latch_strobe_oe), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .lane_strobe_n(lane_strobe_n), .data_pin_oe(data_pin_oe), .ack_ready_oe(ack_ready_oe));

// ---- ebpc_partner.sv ----
`timescale 1ns/10ps
module ebpc_partner (
    input  wire logic        link_clk,
    input  wire logic [5:0]  ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [3:0]  lane_n,
    input  wire logic [15:0] addr,
    input  wire logic        latch_n,
    input  wire logic [31:0] data,
    input  wire logic [3:0]  ack_delay,
    output logic      [31:0] drive,
    output logic             ack_n,
    output logic      [15:0] upper
);
    logic [31:0] mem [16];
    logic [3:0]  cnt = 4'h0;
    logic [7:0]  tick = 8'h5a;
    wire logic   sel = ce_n != 6'h3f;
    wire logic   strobe = sel && (!oe_n || !we_n);
    // A released bus shows a moving pattern so that a stale value never passes.
    assign drive = (sel && !oe_n) ? mem[addr[3:0]] : {4{tick}};
    // The pin is pulled up and only pulled low to acknowledge after the set delay.
    assign ack_n = !(strobe && cnt >= ack_delay);
    always @(posedge link_clk) begin
        tick <= tick + 8'h1;
        cnt <= strobe ? cnt + 4'h1 : 4'h0;
        if (!latch_n) upper <= addr;
        for (int i = 0; i < 4; i++) begin
            if (sel && !we_n && !lane_n[i]) mem[addr[3:0]][8*i+:8] <= data[8*i+:8];
        end
    end
endmodule

// ---- external_bus_pin_control_bench.sv ----
`timescale 1ns/10ps
module external_bus_pin_control_bench;
    logic        hclk = 1'b0;
    logic        link_clk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdv, d_out, d_in, drive;
    logic        hreadyout, io_clk, a_oe, ul_n, ul_oe, ul_w_n, oe_n, we_n, d_oe, ack_n;
    logic [15:0] a_out, a_in, upper;
    logic [15:0] strap = 16'h0;
    logic [5:0]  ce_n, seen_ce;
    logic [3:0]  lane_n, seen_lw, seen_lr;
    logic [3:0]  ack_delay = 4'h0;
    logic        chk_ph = 1'b0;
    logic [63:0] exp_q [$];
    logic [31:0] rnd = 32'h00010761;
    int          slen;
    int          error_cnt = 0;
    int          samples_checked = 0;
    assign a_in = a_oe ? a_out : strap;
    assign d_in = d_oe ? d_out : drive;
    assign ul_w_n = ul_oe ? ul_n : 1'b1;
    ebpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link_clk(link_clk),
        .ext_io_clock(io_clk), .addr_pin_in(a_in), .addr_pin_out(a_out), .addr_pin_oe(a_oe),
        .upper_addr_latch_strobe_in(ul_w_n), .upper_addr_latch_strobe_out(ul_n),
        .upper_addr_latch_strobe_oe(ul_oe), .chip_enable_n(ce_n), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .lane_strobe_n(lane_n), .data_pin_in(d_in),
        .data_pin_out(d_out), .data_pin_oe(d_oe), .ack_ready_in(ack_n),
        .ack_ready_out(), .ack_ready_oe());
    ebpc_partner mem_u (.link_clk(link_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .lane_n(lane_n), .addr(a_in), .latch_n(ul_w_n), .data(d_in), .ack_delay(ack_delay),
        .drive(drive), .ack_n(ack_n), .upper(upper));
    initial forever #10 hclk = ~hclk;
    // The offset keeps link edges away from bus edges, so the two never race.
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        if (chk_ph === 1'b1 && exp_q.size() > 0) begin
            cmp(hrdata & exp_q[0][63:32], exp_q[0][31:0], "read data");
            void'(exp_q.pop_front());
        end
    end
    always @(posedge link_clk) begin
        seen_ce &= ce_n;
        if (!we_n) seen_lw &= lane_n;
        if (!oe_n) seen_lr &= lane_n;
        if (!oe_n || !we_n) slen++;
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        chk_ph <= c;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk_ph <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        ahb(1'b0, a, 32'h0, 1'b1);
    endtask
    task automatic do_reset(input logic [15:0] s);
        strap <= s;
        hresetn <= 1'b0;
        repeat (3) @(posedge link_clk);
        cmp({31'h0, ul_oe}, 32'h0, "latch pin in reset");
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        cmp({31'h0, ul_oe}, 32'h1, "latch pin after reset");
    endtask
    task automatic meas_clk(input logic [1:0] r);
        realtime t0, t1, t2;
        @(posedge io_clk);
        t0 = $realtime;
        @(negedge io_clk);
        t1 = $realtime;
        @(posedge io_clk);
        t2 = $realtime;
        cmp(32'(int'(t2 - t0)), 32'(20 * (r + 1)), "io clock period");
        cmp(32'(int'(t1 - t0)), (r == 2'h2) ? 32'd20 : 32'(10 * (r + 1)), "io clock high");
    endtask
    task automatic access(input logic w, input int ce, input logic [3:0] ln);
        int n;
        seen_ce = 6'h3f;
        seen_lw = 4'hf;
        seen_lr = 4'hf;
        slen = 0;
        n = 0;
        ahb(1'b1, ebpc_pkg::REG_CMD, {24'h0, ln, 3'(ce), w}, 1'b0);
        rdv = 32'hffff_ffff;
        while (rdv[ebpc_pkg::ST_BUSY_BIT] !== 1'b0 && n < 200) begin
            ahb(1'b0, ebpc_pkg::REG_STATUS, 32'h0, 1'b0);
            n++;
        end
        cmp({31'h0, rdv[ebpc_pkg::ST_BUSY_BIT]}, 32'h0, "busy clears");
    endtask
    initial begin
        logic [1:0] rr;
        logic [3:0] wm;
        logic [31:0] a, d, d2, e, bm;
        int wd;
        #1500000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        logic [1:0] rr;
        logic [3:0] wm;
        logic [31:0] a, d, d2, e, bm;
        int wd;
        for (int r = 0; r < 4; r++) begin
            rr = 2'(r);
            do_reset({4'h0, rr[0], 6'h0, rr, 3'h0});
            chk_rd(ebpc_pkg::REG_CFG, ebpc_pkg::CFG_RESET, 32'hffff_ffff);
            chk_rd(ebpc_pkg::REG_STATUS, {26'h0, 3'h5, rr[0], rr}, 32'h2f);
            strap <= ~strap;
            meas_clk(rr);
            chk_rd(ebpc_pkg::REG_STATUS, {26'h0, 3'h5, rr[0], rr}, 32'h2f);
        end
        ahb(1'b1, 8'h3c, 32'h1234_5678, 1'b0);
        chk_rd(8'h3c, 32'h0, 32'hffff_ffff);
        ahb(1'b1, ebpc_pkg::REG_CFG, 32'h0, 1'b0);
        repeat (4) @(posedge hclk);
        repeat (12) begin
            @(negedge hclk);
            cmp({31'h0, io_clk}, 32'h0, "io clock parked");
        end
        for (int k = 0; k < 6; k++) begin
            wd = k % 3;
            wm = (wd == 0) ? 4'hf : (wd == 1) ? 4'h3 : 4'h1;
            bm = {{8{wm[3]}}, {8{wm[2]}}, {8{wm[1]}}, {8{wm[0]}}};
            ack_delay <= (k == 4) ? 4'h0 : 4'h7;
            rnd = xs(rnd);
            a = rnd;
            rnd = xs(rnd);
            d = rnd;
            d2 = xs(rnd);
            ahb(1'b1, ebpc_pkg::REG_CFG, 32'h1 | 32'((k >= 3) << 1) | 32'(wd << 2)
                | 32'((k % 2) << (8 + k)), 1'b0);
            ahb(1'b1, ebpc_pkg::REG_ADDR, a, 1'b0);
            ahb(1'b1, ebpc_pkg::REG_WDATA, d, 1'b0);
            access(1'b1, k, 4'hf);
            cmp({26'h0, seen_ce}, {26'h0, ~(6'h1 << k)}, "chip enable");
            cmp({28'h0, seen_lw}, {28'h0, ~wm}, "write lanes");
            cmp({16'h0, upper}, {16'h0, a[31:16]}, "upper address");
            cmp(32'((k >= 3) ? (slen >= int'(ack_delay) + 2) : (slen == 4)), 32'h1,
                "strobe length");
            ahb(1'b1, ebpc_pkg::REG_WDATA, d2, 1'b0);
            access(1'b1, k, 4'h2);
            e = d;
            if (wm[1]) e[15:8] = d2[15:8];
            access(1'b0, k, 4'hf);
            cmp({28'h0, seen_lr}, (k % 2 == 0) ? 32'hf : {28'h0, ~wm}, "read lanes");
            chk_rd(ebpc_pkg::REG_RDATA, e, bm);
        end
        report_and_stop;
    end
endmodule
